/* hdl/dcr_pkg.sv */
// package: register map, field positions, reset values and timing for the converter control block
`default_nettype none
package dcr_pkg;
  // ****************************************************************
  // register offsets within one instance
  // ****************************************************************
  localparam logic [5:0] OFS_ACTIVATE = 6'h00;
  localparam logic [5:0] OFS_CONFIG   = 6'h04;
  localparam logic [5:0] OFS_CONTROL  = 6'h08;
  localparam logic [5:0] OFS_CODE     = 6'h0C;
  localparam logic [5:0] OFS_RSV_LO   = 6'h10;
  localparam logic [5:0] OFS_RSV_HI   = 6'h30;

  // instance base addresses in the controller space
  localparam logic [31:0] BASE_INST0 = 32'h0000_8000;
  localparam logic [31:0] BASE_INST1 = 32'h0000_8040;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ACT_BIT        = 0;
  localparam int CFG_INTRL_BIT  = 0;
  localparam int CFG_PIN_BIT    = 1;
  localparam int CFG_SLEEP_BIT  = 2;
  localparam int CTL_ON_BIT     = 0;
  localparam int CTL_SRST_BIT   = 1;
  localparam int CODE_W         = 12;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic        ACT_RST  = 1'b0;
  localparam logic [2:0]  CFG_RST  = 3'h0;
  localparam logic        ON_RST   = 1'b0;
  localparam logic [11:0] CODE_RST = 12'h000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ       = 100;
  localparam int SETTLE_NS     = 1000;  // one sample at 1 Msps
  localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ) / 1000;
  localparam int SRST_NS       = 150;   // least wait after soft reset
  localparam int SRST_CYC      = (SRST_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    DCR_DEACT = 3'h0,
    DCR_SLEEP = 3'h1,
    DCR_OFF   = 3'h2,
    DCR_ON    = 3'h3,
    DCR_CONV  = 3'h4
  } dcr_state_e;

  typedef struct packed {
    logic        sleep_honor;
    logic        pin_buffer_enable;
    logic        internal_buffer_enable;
  } dcr_cfg_s;

  typedef struct packed {
    logic        analog_power;
    logic        clock_enable;
    logic        pin_buffer_on;
    logic        internal_buffer_on;
    logic        output_tristate;
    logic [11:0] code;
  } dcr_analog_s;
endpackage
`default_nettype wire

/* hdl/dcr_power_fsm.sv */
// module: power-state sequencer of the converter
`default_nettype none
module dcr_power_fsm (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic                local_rst,
  // control inputs
  input  wire logic                activate,
  input  wire logic                sleep_req,
  input  wire logic                sleep_honor,
  input  wire logic                output_on_flag,
  input  wire logic                code_change,
  // state
  output dcr_pkg::dcr_state_e      state
);
  localparam int CW = $clog2(dcr_pkg::SETTLE_CYC + 1);

  dcr_pkg::dcr_state_e state_q;
  dcr_pkg::dcr_state_e state_d;
  logic [CW-1:0]       settle_q;
  logic                on_prev_q;
  logic                change;

  // a toggle of the on bit or a new code is a change; a new code while on starts a conversion
  assign change = code_change | (output_on_flag != on_prev_q);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    if (!activate) begin
      state_d = dcr_pkg::DCR_DEACT;
    end else if (sleep_req && sleep_honor) begin
      state_d = dcr_pkg::DCR_SLEEP;
    end else begin
      case (state_q)
        dcr_pkg::DCR_DEACT,
        dcr_pkg::DCR_SLEEP,
        dcr_pkg::DCR_OFF: begin
          state_d = output_on_flag ? dcr_pkg::DCR_CONV : dcr_pkg::DCR_OFF;
        end
        dcr_pkg::DCR_ON: begin
          if (change) begin
            state_d = output_on_flag ? dcr_pkg::DCR_CONV : dcr_pkg::DCR_OFF;
          end
        end
        dcr_pkg::DCR_CONV: begin
          if (!output_on_flag) begin
            state_d = dcr_pkg::DCR_OFF;
          end else if (settle_q == CW'(dcr_pkg::SETTLE_CYC - 1) && !change) begin
            state_d = dcr_pkg::DCR_ON;
          end
        end
        default: state_d = dcr_pkg::DCR_OFF;
      endcase
    end
  end

  // state register; local reset returns to off then re-evaluates
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= dcr_pkg::DCR_DEACT;
    end else if (clk_en) begin
      state_q <= local_rst ? dcr_pkg::DCR_OFF : state_d;
    end
  end

  // settle counter restarts on every change so the code holds a full sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_q  <= '0;
      on_prev_q <= dcr_pkg::ON_RST;
    end else if (clk_en) begin
      on_prev_q <= local_rst ? dcr_pkg::ON_RST : output_on_flag;
      if (local_rst || state_q != dcr_pkg::DCR_CONV || change) begin
        settle_q <= '0;
      end else if (settle_q != CW'(dcr_pkg::SETTLE_CYC - 1)) begin
        settle_q <= settle_q + CW'(1);
      end
    end
  end

  assign state = state_q;
endmodule
`default_nettype wire

/* hdl/dcr_top.sv */
// module: register file and analog control for one converter instance
`default_nettype none
module dcr_top #(
  parameter logic [31:0] BASE_ADDR = dcr_pkg::BASE_INST0
) (
  // clock and reset (ring oscillator domain)
  // sys_clk stands in for the ring oscillator; every flop here runs on it
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // register port from the controller
  input  wire logic [31:0]         reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata,
  // chip sleep request, asynchronous to this clock
  input  wire logic                sleep_en_pin,
  // analog controls
  output dcr_pkg::dcr_analog_s     analog,
  output dcr_pkg::dcr_state_e      power_state
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                 active_q;
  dcr_pkg::dcr_cfg_s    cfg_q;
  logic                 output_on_flag_q;
  logic [11:0]          code_q;
  logic                 srst_q;
  logic                 sleep_s1_q;
  logic                 sleep_s2_q;
  logic                 code_change_q;
  logic                 local_rst;
  logic                 hit;
  logic [5:0]           ofs;
  logic                 wr_act;
  logic                 wr_cfg;
  logic                 wr_ctl;
  logic                 wr_code;
  dcr_pkg::dcr_state_e  state;
  logic                 ladder_live;
  logic                 clocks_run;
  logic                 sleeping;
  logic                 drive_ok;
  logic                 power_q;
  logic                 clken_q;
  logic                 pin_buf_q;
  logic                 int_buf_q;
  logic                 tristate_q;
  logic [11:0]          code_out_q;

  // address decode: a 64-byte window per instance, byte offsets
  assign hit     = (reg_addr[31:6] == BASE_ADDR[31:6]);
  assign ofs     = reg_addr[5:0];
  assign wr_act  = clk_en & reg_wr & hit & (ofs == dcr_pkg::OFS_ACTIVATE);
  assign wr_cfg  = clk_en & reg_wr & hit & (ofs == dcr_pkg::OFS_CONFIG);
  assign wr_ctl  = clk_en & reg_wr & hit & (ofs == dcr_pkg::OFS_CONTROL);
  assign wr_code = clk_en & reg_wr & hit & (ofs == dcr_pkg::OFS_CODE);

  // local reset is the one-cycle soft reset pulse; system reset is async
  assign local_rst = srst_q;

  // ****************************************************************
  // sleep request synchroniser
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else if (clk_en) begin
      sleep_s1_q <= sleep_en_pin;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // ****************************************************************
  // activate register: a write of zero or the system reset clears it; soft reset leaves it
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_q <= dcr_pkg::ACT_RST;
    end else if (wr_act) begin
      active_q <= reg_wdata[dcr_pkg::ACT_BIT];
    end
  end

  // ****************************************************************
  // configuration register, locked while output is on
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= dcr_dcfg_rst();
    end else if (clk_en) begin
      if (local_rst) begin
        cfg_q <= dcr_dcfg_rst();
      end else if (wr_cfg && !output_on_flag_q) begin
        cfg_q.sleep_honor            <= reg_wdata[dcr_pkg::CFG_SLEEP_BIT];
        cfg_q.pin_buffer_enable      <= reg_wdata[dcr_pkg::CFG_PIN_BIT];
        cfg_q.internal_buffer_enable <= reg_wdata[dcr_pkg::CFG_INTRL_BIT];
      end
    end
  end

  function automatic dcr_pkg::dcr_cfg_s dcr_dcfg_rst();
    dcr_pkg::dcr_cfg_s c;
    c = dcr_pkg::CFG_RST;
    return c;
  endfunction

  // ****************************************************************
  // control register: output on and self-clearing soft reset
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_on_flag_q <= dcr_pkg::ON_RST;
    end else if (clk_en) begin
      if (local_rst) begin
        output_on_flag_q <= dcr_pkg::ON_RST;
      end else if (wr_ctl && !reg_wdata[dcr_pkg::CTL_SRST_BIT]) begin
        // on cannot be set while the block is deactivated
        output_on_flag_q <= reg_wdata[dcr_pkg::CTL_ON_BIT] & active_q;
      end
    end
  end

  // soft reset pulses one cycle; writing zero does nothing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      srst_q <= 1'b0;
    end else if (clk_en) begin
      srst_q <= wr_ctl & reg_wdata[dcr_pkg::CTL_SRST_BIT];
    end
  end

  // ****************************************************************
  // output code register; whole field in one access
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      code_q        <= dcr_pkg::CODE_RST;
      code_change_q <= 1'b0;
    end else if (clk_en) begin
      if (local_rst) begin
        code_q        <= dcr_pkg::CODE_RST;
        code_change_q <= 1'b0;
      end else begin
        if (wr_code) begin
          code_q <= reg_wdata[dcr_pkg::CODE_W-1:0];
        end
        code_change_q <= wr_code && (reg_wdata[dcr_pkg::CODE_W-1:0] != code_q);
      end
    end
  end

  // ****************************************************************
  // read mux; reserved bits and unmapped offsets read zero
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (reg_rd && hit) begin
        case (ofs)
          dcr_pkg::OFS_ACTIVATE: reg_rdata <= {31'h0, active_q};
          dcr_pkg::OFS_CONFIG:   reg_rdata <= {29'h0, cfg_q};
          dcr_pkg::OFS_CONTROL:  reg_rdata <= {31'h0, output_on_flag_q};
          dcr_pkg::OFS_CODE:     reg_rdata <= {20'h0, code_q};
          default:               reg_rdata <= 32'h0000_0000;  // reserved slots
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // power-state sequencer
  // ****************************************************************
  dcr_power_fsm u_fsm (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .clk_en         (clk_en),
    .local_rst      (local_rst),
    .activate       (active_q),
    .sleep_req      (sleep_s2_q),
    .sleep_honor    (cfg_q.sleep_honor),
    .output_on_flag (output_on_flag_q),
    .code_change    (code_change_q),
    .state          (state)
  );

  // ****************************************************************
  // analog controls, registered; no interrupt exists
  // ****************************************************************
  // state decodes shared by the output flops below
  assign ladder_live = (state == dcr_pkg::DCR_ON) ||
                       (state == dcr_pkg::DCR_CONV);
  assign clocks_run  = (state != dcr_pkg::DCR_DEACT) &&
                       (state != dcr_pkg::DCR_SLEEP);
  assign sleeping    = (state == dcr_pkg::DCR_SLEEP);
  assign drive_ok    = output_on_flag_q && !sleeping;

  // ladder power only in on and converting; off still runs the converter clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      power_q <= 1'b0;
    end else if (clk_en) begin
      power_q <= ladder_live;
    end
  end

  // converter clock gated while deactivated or asleep
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clken_q <= 1'b0;
    end else if (clk_en) begin
      clken_q <= clocks_run;
    end
  end

  // pin buffer needs its enable and the on bit, and is off in sleep
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_buf_q <= 1'b0;
    end else if (clk_en) begin
      pin_buf_q <= cfg_q.pin_buffer_enable && drive_ok;
    end
  end

  // internal buffer feeds the comparator path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_buf_q <= 1'b0;
    end else if (clk_en) begin
      int_buf_q <= cfg_q.internal_buffer_enable && drive_ok;
    end
  end

  // output floats only while sleep is honoured
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tristate_q <= 1'b0;
    end else if (clk_en) begin
      tristate_q <= sleeping;
    end
  end

  // code copied as one word so the ladder never sees a half update
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      code_out_q <= dcr_pkg::CODE_RST;
    end else if (clk_en) begin
      code_out_q <= code_q;
    end
  end

  // packed view for the analog side; every field is a flop
  assign analog = '{
    analog_power:       power_q,
    clock_enable:       clken_q,
    pin_buffer_on:      pin_buf_q,
    internal_buffer_on: int_buf_q,
    output_tristate:    tristate_q,
    code:               code_out_q
  };

  assign power_state = state;
endmodule
`default_nettype wire

/* tb/dcr_monitor.sv */
// checker: port-level assertions for the converter control block
`default_nettype none
module dcr_monitor #(
  parameter logic [31:0] BASE_ADDR = dcr_pkg::BASE_INST0
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // register port
  input  wire logic [31:0]          reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic [31:0]          reg_rdata,
  // sleep and analog side
  input  wire logic                 sleep_en_pin,
  input  wire dcr_pkg::dcr_analog_s analog,
  input  wire dcr_pkg::dcr_state_e  power_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // helpers
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] conv_cnt_q;
  logic       miss;
  // offsets above the data register or another base are unmapped
  assign miss = (reg_addr[31:6] != BASE_ADDR[31:6]) || (reg_addr[5:2] > 4'h3);
  // run length of converting; saturates so restarts cannot wrap it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) conv_cnt_q <= 8'h00;
    else if (power_state != dcr_pkg::DCR_CONV) conv_cnt_q <= 8'h00;
    else if (conv_cnt_q != 8'hFF) conv_cnt_q <= conv_cnt_q + 8'h01;
  end
  // ****
  // assertions
  // ****
  AST_RD_IDLE: assert property (!$past(reg_rd) && $past(clk_en) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_RD_UNMAPPED: assert property ($past(reg_rd && miss && clk_en) |-> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  AST_FREEZE: assert property (!clk_en |=> $stable(power_state) && $stable(analog))
    else $error("state moved with clock enable low");
  AST_DEACT_OFF: assert property (power_state == dcr_pkg::DCR_DEACT [*2] |->
    !analog.analog_power && !analog.clock_enable)
    else $error("analog live while deactivated");
  AST_SLEEP_TRI: assert property (power_state == dcr_pkg::DCR_SLEEP [*2] |->
    analog.output_tristate && !analog.analog_power && !analog.pin_buffer_on)
    else $error("output not tristated in sleep");
  AST_SLEEP_CAUSE: assert property ($rose(power_state == dcr_pkg::DCR_SLEEP) |->
    $past(sleep_en_pin, 2))
    else $error("sleep entered without request");
  AST_OFF_QUIET: assert property (power_state == dcr_pkg::DCR_OFF [*2] |->
    !analog.analog_power && !analog.pin_buffer_on && !analog.internal_buffer_on)
    else $error("analog live while off");
  AST_ON_LIVE: assert property (power_state == dcr_pkg::DCR_ON [*2] |->
    analog.analog_power && !analog.output_tristate)
    else $error("analog dead while on");
  AST_CONV_LEN: assert property ($past(power_state) == dcr_pkg::DCR_CONV &&
    power_state == dcr_pkg::DCR_ON |-> conv_cnt_q >= 8'(dcr_pkg::SETTLE_CYC))
    else $error("converting phase too short");
  // main scenarios reached
  cover property (power_state == dcr_pkg::DCR_CONV);
  cover property (power_state == dcr_pkg::DCR_SLEEP);
  cover property ($past(power_state) == dcr_pkg::DCR_ON && power_state == dcr_pkg::DCR_DEACT);
endmodule

bind dcr_top dcr_monitor #(.BASE_ADDR(BASE_ADDR)) u_dcr_monitor (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sleep_en_pin(sleep_en_pin), .analog(analog), .power_state(power_state)
);
`default_nettype wire

/* tb/dcr_top_tb.sv */
// testbench: register-level tests of the converter control block
`default_nettype none
module dcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_ACT = dcr_pkg::BASE_INST0;
  localparam logic [31:0] A_CFG = A_ACT + 32'h4;
  localparam logic [31:0] A_CTL = A_ACT + 32'h8;
  localparam logic [31:0] A_COD = A_ACT + 32'hC;
  localparam int          W     = dcr_pkg::SETTLE_CYC + 5;
  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 clk_en = 1'b1;
  logic [31:0]          reg_addr = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 sleep_en_pin = 1'b0;
  logic [31:0]          reg_rdata;
  dcr_pkg::dcr_analog_s analog;
  dcr_pkg::dcr_state_e  power_state;
  int                   fail_count = 0;
  int                   checked = 0;

  // free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  dcr_top #(.BASE_ADDR(A_ACT)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sleep_en_pin(sleep_en_pin), .analog(analog), .power_state(power_state)
  );

  // ****
  // access tasks
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error: %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic st(input dcr_pkg::dcr_state_e e);
    chk("state", 32'(e), 32'(power_state));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data lands the cycle after the strobe is taken
  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog; the whole run needs about 770 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd("activate", A_ACT, 32'h0);
    rd("config", A_CFG, 32'h0);
    rd("control", A_CTL, 32'h0);
    rd("code", A_COD, 32'h0);
    wr(A_ACT + 32'h30, 32'hFFFF_FFFF);
    rd("reserved", A_ACT + 32'h30, 32'h0);
    rd("other_base", dcr_pkg::BASE_INST1 + 32'hC, 32'h0);
    st(dcr_pkg::DCR_DEACT);
    done("reset");
    wr(A_CTL, 32'h1);
    rd("control", A_CTL, 32'h0);
    wr(A_CFG, 32'h3);
    rd("config", A_CFG, 32'h3);
    done("deactivated");
    wr(A_ACT, 32'h1);
    wr(A_COD, 32'hFFFF_FABC);
    rd("code", A_COD, 32'hABC);
    wr(A_CTL, 32'h1);
    cyc(3);
    st(dcr_pkg::DCR_CONV);
    cyc(W);
    st(dcr_pkg::DCR_ON);
    chk("code_out", 32'hABC, 32'(analog.code));
    chk("pin_buf", 32'h1, 32'(analog.pin_buffer_on));
    chk("int_buf", 32'h1, 32'(analog.internal_buffer_on));
    wr(A_CFG, 32'h4);
    rd("config", A_CFG, 32'h3);
    done("power_up");
    wr(A_COD, 32'h5A5);
    cyc(3);
    st(dcr_pkg::DCR_CONV);
    cyc(W);
    chk("code_out", 32'h5A5, 32'(analog.code));
    @(posedge sys_clk);
    sleep_en_pin <= 1'b1;
    cyc(10);
    st(dcr_pkg::DCR_ON);
    chk("tristate", 32'h0, 32'(analog.output_tristate));
    @(posedge sys_clk);
    sleep_en_pin <= 1'b0;
    done("update");
    wr(A_CTL, 32'h0);
    cyc(W);
    st(dcr_pkg::DCR_OFF);
    chk("power", 32'h0, 32'(analog.analog_power));
    wr(A_CFG, 32'h4);
    rd("config", A_CFG, 32'h4);
    wr(A_CTL, 32'h1);
    cyc(W);
    chk("pin_buf", 32'h0, 32'(analog.pin_buffer_on));
    chk("int_buf", 32'h0, 32'(analog.internal_buffer_on));
    @(posedge sys_clk);
    sleep_en_pin <= 1'b1;
    cyc(10);
    st(dcr_pkg::DCR_SLEEP);
    chk("tristate", 32'h1, 32'(analog.output_tristate));
    @(posedge sys_clk);
    sleep_en_pin <= 1'b0;
    cyc(W + 10);
    st(dcr_pkg::DCR_ON);
    done("sleep");
    // a write during a frozen clock must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(A_COD, 32'h111);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd("code", A_COD, 32'h5A5);
    wr(A_CTL, 32'h3);
    cyc(3);
    rd("activate", A_ACT, 32'h1);
    rd("config", A_CFG, 32'h0);
    rd("control", A_CTL, 32'h0);
    rd("code", A_COD, 32'h0);
    cyc(W);
    st(dcr_pkg::DCR_OFF);
    done("soft_reset");
    wr(A_CTL, 32'h1);
    cyc(5);
    wr(A_ACT, 32'h0);
    cyc(5);
    st(dcr_pkg::DCR_DEACT);
    chk("power", 32'h0, 32'(analog.analog_power));
    @(posedge sys_clk);
    resetn <= 1'b0;
    cyc(2);
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd("activate", A_ACT, 32'h0);
    rd("control", A_CTL, 32'h0);
    done("system_reset");
    give_verdict();
  end
endmodule
`default_nettype wire
